//--- rtl/frc_top.sv
// fixed reference control: ahb-lite register bank and analog control outputs
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
`include "frc_defines.svh"
module frc_top
  import frc_pkg::*;
#(
  // set for the variant with the internal low-dropout regulator
  parameter bit LDO_VARIANT = 1'b0
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // analog status from the reference: its stable indication
  input wire logic ref_stable_async,
  // reference control
  output logic reference_enable,
  output logic reference_ready,
  // temperature indicator control
  output logic temp_sense_enable,
  output logic temp_sense_range,
  // comparator/dac path gain
  output logic [1:0] cmp_dac_gain_select,
  output logic [2:0] cmp_dac_gain,
  output logic cmp_dac_out_en,
  // converter path gain
  output logic [1:0] converter_gain_select,
  output logic [2:0] converter_gain,
  output logic converter_out_en,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus phase tracking

  logic addr_take;
  logic dph_valid_r;
  logic dph_write_r;
  logic [`FRC_ADDR_W-1:0] dph_addr_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic wr_strobe;
  logic rd_strobe;

  // register state
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] ctrl_view;
  logic ready_r;
  logic ready_nxt;
  logic settle_done;
  logic [`FRC_EV_W-1:0] status_r;
  logic [`FRC_EV_W-1:0] status_nxt;
  logic [`FRC_EV_W-1:0] mask_r;
  logic [`FRC_EV_W-1:0] events;
  logic irq_r;

  // output copies
  frc_gain_t cda_gain_r;
  frc_gain_t adc_gain_r;
  logic cda_on_r;
  logic adc_on_r;
  logic [1:0] cda_sel_nxt;
  logic [1:0] adc_sel_nxt;

  // decoded register selects and strobes
  logic sel_ctrl;
  logic sel_status;
  logic sel_mask;
  logic sel_info;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_status;

  function automatic logic hit(input logic [`FRC_ADDR_W-1:0] a,
                               input logic [`FRC_ADDR_W-1:0] off);
    return a == off;
  endfunction : hit

  // the address phase is captured only while the bus is ready; during the
  // read wait state the captured phase must stay put for the read strobe
  // only htrans nonseq/seq with the bus ready open a transfer
  assign addr_take = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r <= '0;
    end
    else if (hready)
    begin
      dph_valid_r <= addr_take;
      if (addr_take)
      begin
        dph_write_r <= hwrite;
        dph_addr_r <= haddr[`FRC_ADDR_W-1:0];
      end
    end
  end

  // reads take one wait state so a write just before is always seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout_r <= 1'b1;
    else if (addr_take && !hwrite)
      hreadyout_r <= 1'b0;
    else
      hreadyout_r <= 1'b1;
  end

  // hsize is not checked: every access is treated as a whole word
  // writes finish with no wait state, so hwdata is used on the edge that
  // ends the data phase; reads are answered one edge later from a register
  assign wr_strobe = dph_valid_r && dph_write_r && hready;
  assign rd_strobe = dph_valid_r && !dph_write_r && !hreadyout_r;

  // decode the captured offset once; the register processes share it
  always_comb
  begin
    sel_ctrl = hit(dph_addr_r, `FRC_OFF_CTRL);
    sel_status = hit(dph_addr_r, `FRC_OFF_STATUS);
    sel_mask = hit(dph_addr_r, `FRC_OFF_MASK);
    sel_info = hit(dph_addr_r, `FRC_OFF_INFO);
  end

  assign wr_ctrl = wr_strobe && sel_ctrl;
  assign wr_mask = wr_strobe && sel_mask;
  assign rd_status = rd_strobe && sel_status;

  ////////////////////////////////////////////////////////////////////////////
  // control register

  // the ready position is masked off here and rebuilt from hardware state
  // on reads, so software can never fake a settled reference
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
      ctrl_nxt = hwdata[7:0] & `FRC_CTRL_WMASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= `FRC_CTRL_RST;
    else
      ctrl_r <= ctrl_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stabilisation and ready flag

  // the tracker enforces the minimum wait and also needs the analog side to
  // report stable; a drop of stable while ready restarts the full wait, so
  // a glitching reference never shows ready for a few cycles only
  frc_settle u_settle (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(ctrl_r[`FRC_BIT_REF_EN]),
    .stable_async(ref_stable_async),
    .done(settle_done)
  );

  // on the regulator variant the flag is fixed high and never makes events
  always_comb
  begin
    if (LDO_VARIANT)
      ready_nxt = 1'b1;
    else
      ready_nxt = ctrl_r[`FRC_BIT_REF_EN] && settle_done;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ready_r <= LDO_VARIANT;
    else
      ready_r <= ready_nxt;
  end

  // the ready position shows hardware state, never the stored bit
  always_comb
  begin
    ctrl_view = ctrl_r;
    ctrl_view[`FRC_BIT_READY] = ready_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and line

  // events come from the next value of the flag, so the status bit and the
  // irq line move on the same edge as the flag itself
  always_comb
  begin
    events = '0;
    events[`FRC_EV_RISE] = ready_nxt && !ready_r;
    events[`FRC_EV_FALL] = !ready_nxt && ready_r;
  end

  // a read clears the status, but an event in the same cycle survives
  always_comb
  begin
    status_nxt = status_r;
    if (rd_status)
      status_nxt = '0;
    status_nxt = status_nxt | events;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_r <= `FRC_STATUS_RST;
    else
      status_r <= status_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask_r <= `FRC_MASK_RST;
    else if (wr_mask)
      mask_r <= hwdata[`FRC_EV_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(status_nxt & mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  // unmapped offsets read as zero; the info word tells software which
  // variant it talks to, since the ready flag alone cannot show it while
  // the reference is enabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0000_0000;
    else if (rd_strobe)
    begin
      if (sel_ctrl)
        hrdata_r <= {24'h00_0000, ctrl_view};
      else if (sel_status)
        hrdata_r <= {{(32-`FRC_EV_W){1'b0}}, status_r};
      else if (sel_mask)
        hrdata_r <= {{(32-`FRC_EV_W){1'b0}}, mask_r};
      else if (sel_info)
        hrdata_r <= {31'h0000_0000, LDO_VARIANT};
      else
        hrdata_r <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded gain outputs; each path uses only its own field

  // pick each field from the value the register takes next, so the decoded
  // outputs change on the same edge as the stored selects
  always_comb
  begin
    cda_sel_nxt = ctrl_nxt[`FRC_CDA_HI:`FRC_CDA_LO];
    adc_sel_nxt = ctrl_nxt[`FRC_ADC_HI:`FRC_ADC_LO];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cda_gain_r <= 3'h0;
      cda_on_r <= 1'b0;
    end
    else
    begin
      cda_gain_r <= frc_gain_decode(cda_sel_nxt);
      cda_on_r <= (cda_sel_nxt != `FRC_GAIN_OFF);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      adc_gain_r <= 3'h0;
      adc_on_r <= 1'b0;
    end
    else
    begin
      adc_gain_r <= frc_gain_decode(adc_sel_nxt);
      adc_on_r <= (adc_sel_nxt != `FRC_GAIN_OFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port drive, all from flops except the tied hresp

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  // hresp is tied: every transfer completes with an okay response
  assign hresp = 1'b0;
  assign reference_enable = ctrl_r[`FRC_BIT_REF_EN];
  assign reference_ready = ready_r;
  assign temp_sense_enable = ctrl_r[`FRC_BIT_TS_EN];
  assign temp_sense_range = ctrl_r[`FRC_BIT_TS_RNG];
  // selects are shown raw beside the decoded one-hot gain and enables
  assign cmp_dac_gain_select = ctrl_r[`FRC_CDA_HI:`FRC_CDA_LO];
  assign converter_gain_select = ctrl_r[`FRC_ADC_HI:`FRC_ADC_LO];
  assign cmp_dac_gain = cda_gain_r;
  assign cmp_dac_out_en = cda_on_r;
  assign converter_gain = adc_gain_r;
  assign converter_out_en = adc_on_r;
  assign irq = irq_r;

endmodule : frc_top

//--- common/frc_defines.svh
// register map, field positions, reset values and timing for fixed_reference
`ifndef FRC_DEFINES_SVH
`define FRC_DEFINES_SVH

// byte offsets inside the slave window
`define FRC_ADDR_W 12
`define FRC_OFF_CTRL 12'h000
`define FRC_OFF_STATUS 12'h004
`define FRC_OFF_MASK 12'h008
`define FRC_OFF_INFO 12'h00c

// reference_control_reg field positions
`define FRC_BIT_REF_EN 7
`define FRC_BIT_READY 6
`define FRC_BIT_TS_EN 5
`define FRC_BIT_TS_RNG 4
`define FRC_CDA_HI 3
`define FRC_CDA_LO 2
`define FRC_ADC_HI 1
`define FRC_ADC_LO 0

// reset values and write mask (ready position is not writable)
`define FRC_CTRL_RST 8'h00
`define FRC_CTRL_WMASK 8'hbf
`define FRC_EV_W 2
`define FRC_EV_RISE 0
`define FRC_EV_FALL 1
`define FRC_STATUS_RST 2'h0
`define FRC_MASK_RST 2'h0
`define FRC_INFO_LDO 0

// gain select codes
`define FRC_GAIN_OFF 2'h0
`define FRC_GAIN_X1 2'h1
`define FRC_GAIN_X2 2'h2
`define FRC_GAIN_X4 2'h3

// stabilisation wait: time in ns, count in hclk cycles rounded up
`define FRC_CLK_NS 20
`define FRC_SETTLE_NS 25000
`define FRC_SETTLE_CYC ((`FRC_SETTLE_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)
`define FRC_SETTLE_CW 11

`endif

//--- common/frc_pkg.sv
// types and gain decode shared by the fixed reference control block
`include "frc_defines.svh"
package frc_pkg;

  // one-hot gain: bit0 1x, bit1 2x, bit2 4x, all zero is off
  typedef logic [2:0] frc_gain_t;

  typedef enum logic [1:0] {
    FRC_ST_OFF,
    FRC_ST_WAIT,
    FRC_ST_READY
  } frc_settle_state_t;

  function automatic frc_gain_t frc_gain_decode(input logic [1:0] sel);
    frc_gain_t g;
    g = 3'h0;
    case (sel)
      `FRC_GAIN_X1: g = 3'h1;
      `FRC_GAIN_X2: g = 3'h2;
      `FRC_GAIN_X4: g = 3'h4;
      default: g = 3'h0;
    endcase
    return g;
  endfunction : frc_gain_decode

endpackage : frc_pkg

//--- rtl/frc_settle.sv
// stabilisation tracker: minimum wait plus the analog stable indication
`timescale 1ns/100ps
`include "frc_defines.svh"
module frc_settle
  import frc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control and analog status
  input wire logic enable,
  input wire logic stable_async,
  // result
  output logic done
);

  logic sync1_r;
  logic sync2_r;
  logic [`FRC_SETTLE_CW-1:0] cnt_r;
  frc_settle_state_t state_r;
  frc_settle_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // stable comes from the analog side, so it is synchronised first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= stable_async;
      sync2_r <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FRC_ST_OFF:
        if (enable)
          state_nxt = FRC_ST_WAIT;
      FRC_ST_WAIT:
        if (!enable)
          state_nxt = FRC_ST_OFF;
        else if (cnt_r == `FRC_SETTLE_CW'(`FRC_SETTLE_CYC - 1) && sync2_r)
          state_nxt = FRC_ST_READY;
      FRC_ST_READY:
        if (!enable)
          state_nxt = FRC_ST_OFF;
        else if (!sync2_r)
          state_nxt = FRC_ST_WAIT;
      default:
        state_nxt = FRC_ST_OFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= FRC_ST_OFF;
    else
      state_r <= state_nxt;
  end

  // counter saturates at the last cycle of the wait and restarts on reentry
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_r <= '0;
    else if (state_r != FRC_ST_WAIT)
      cnt_r <= '0;
    else if (cnt_r != `FRC_SETTLE_CW'(`FRC_SETTLE_CYC - 1))
      cnt_r <= cnt_r + `FRC_SETTLE_CW'(1);
  end

  assign done = (state_r == FRC_ST_READY);

endmodule : frc_settle

//--- tb/frc_assertions.sv
// assertion checker for the fixed reference control block
`timescale 1ns/100ps
module frc_assertions
#(
  parameter bit LDO_VARIANT = 1'b0
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // control outputs
  input wire logic reference_enable,
  input wire logic reference_ready,
  input wire logic temp_sense_enable,
  input wire logic temp_sense_range,
  input wire logic [1:0] cmp_dac_gain_select,
  input wire logic [2:0] cmp_dac_gain,
  input wire logic cmp_dac_out_en,
  input wire logic [1:0] converter_gain_select,
  input wire logic [2:0] converter_gain,
  input wire logic converter_out_en
);
  logic wr_ctrl_r;
  logic [10:0] en_cnt_r;
  logic taken;
  assign taken = hsel && htrans[1] && hready;
  // counts enabled cycles, saturating so a long enable never wraps
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      en_cnt_r <= 11'h000;
    else if (!reference_enable)
      en_cnt_r <= 11'h000;
    else if (en_cnt_r != 11'h7ff)
      en_cnt_r <= en_cnt_r + 11'h001;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_ctrl_r <= 1'b0;
    else
      wr_ctrl_r <= taken && hwrite && haddr[11:0] == 12'h000;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  property p_en_wr;
    wr_ctrl_r |=> reference_enable == $past(hwdata[7]);
  endproperty
  a_en_wr: assert property (p_en_wr)
    else $error("reference enable does not follow bit 7");
  property p_ts_wr;
    wr_ctrl_r |=> {temp_sense_enable, temp_sense_range} == $past(hwdata[5:4]);
  endproperty
  a_ts_wr: assert property (p_ts_wr)
    else $error("temperature controls do not follow bits 5-4");
  property p_gain_wr;
    wr_ctrl_r |=> {cmp_dac_gain_select, converter_gain_select}
      == $past(hwdata[3:0]);
  endproperty
  a_gain_wr: assert property (p_gain_wr)
    else $error("gain selects do not follow bits 3-0");
  property p_cda_dec;
    cmp_dac_out_en == (cmp_dac_gain_select != 2'h0) &&
      cmp_dac_gain == ((cmp_dac_gain_select == 2'h0) ? 3'h0 :
      3'h1 << (cmp_dac_gain_select - 2'h1));
  endproperty
  a_cda_dec: assert property (p_cda_dec)
    else $error("comparator path gain decode wrong");
  property p_cnv_dec;
    converter_out_en == (converter_gain_select != 2'h0) &&
      converter_gain == ((converter_gain_select == 2'h0) ? 3'h0 :
      3'h1 << (converter_gain_select - 2'h1));
  endproperty
  a_cnv_dec: assert property (p_cnv_dec)
    else $error("converter path gain decode wrong");
  property p_ready_off;
    !LDO_VARIANT && !reference_enable |=> !reference_ready;
  endproperty
  a_ready_off: assert property (p_ready_off)
    else $error("ready set while reference disabled");
  property p_ready_rise;
    !LDO_VARIANT && $rose(reference_ready) |-> en_cnt_r >= 11'h4e2;
  endproperty
  a_ready_rise: assert property (p_ready_rise)
    else $error("ready rose before the settling wait");
  property p_ldo;
    LDO_VARIANT |-> reference_ready;
  endproperty
  a_ldo: assert property (p_ldo)
    else $error("ready not held on regulator variant");
  property p_rd_wait;
    taken && !hwrite |=> !hreadyout ##1 hreadyout && !hresp;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  c_ready: cover property ($rose(reference_ready));
  c_drop: cover property ($fell(reference_ready) && reference_enable);
  c_x4: cover property (wr_ctrl_r && hwdata[3:2] == 2'h3);
endmodule : frc_assertions

bind frc_top frc_assertions #(.LDO_VARIANT(LDO_VARIANT)) i_chk (.hclk,
  .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .reference_enable, .reference_ready, .temp_sense_enable,
  .temp_sense_range, .cmp_dac_gain_select, .cmp_dac_gain, .cmp_dac_out_en,
  .converter_gain_select, .converter_gain, .converter_out_en);

//--- tb/fixed_reference_control_tb.sv
// self-checking bench for the fixed reference control block
`timescale 1ns/100ps
module fixed_reference_control_tb;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic ref_stable_async;
  logic reference_enable;
  logic reference_ready;
  logic temp_sense_enable;
  logic temp_sense_range;
  logic [1:0] cmp_dac_gain_select;
  logic [2:0] cmp_dac_gain;
  logic cmp_dac_out_en;
  logic [1:0] converter_gain_select;
  logic [2:0] converter_gain;
  logic converter_out_en;
  logic irq;
  logic ldo_ready;
  logic [31:0] ldo_hrdata;
  logic [31:0] q;
  int errors;
  int n_tests;

  frc_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ref_stable_async, .reference_enable, .reference_ready,
    .temp_sense_enable, .temp_sense_range, .cmp_dac_gain_select,
    .cmp_dac_gain, .cmp_dac_out_en, .converter_gain_select, .converter_gain,
    .converter_out_en, .irq);
  // regulator variant on the same bus; its hreadyout matches the main one
  frc_top #(.LDO_VARIANT(1'b1)) i_dut_ldo (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata(ldo_hrdata), .hreadyout(), .hresp(), .ref_stable_async,
    .reference_enable(), .reference_ready(ldo_ready),
    .temp_sense_enable(), .temp_sense_range(), .cmp_dac_gain_select(),
    .cmp_dac_gain(), .cmp_dac_out_en(), .converter_gain_select(),
    .converter_gain(), .converter_out_en(), .irq());
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one single transfer; waits on hreadyout, the watchdog bounds a hang
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    @(negedge hclk);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic wait_ready();
    while (reference_ready !== 1'b1) @(posedge hclk);
    @(negedge hclk);
  endtask : wait_ready
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    errors++;
    stop_test();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ref_stable_async = 1'b0;
    errors = 0;
    n_tests = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd(12'(4 * i), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h000, 32'(i * 4 + 3 - i));
      chk({29'h0, cmp_dac_gain}, (i == 0) ? 0 : 1 << (i - 1));
      chk({29'h0, converter_gain}, (i == 3) ? 0 : 4 >> i);
      chk({30'h0, cmp_dac_out_en, converter_out_en},
          {30'h0, i != 0, i != 3});
      rd(12'h000, 32'(i * 4 + 3 - i));
    end
    rd(12'h00c, 32'h0);
    chk(ldo_hrdata, 32'h1);
    chk({31'h0, ldo_ready}, 32'h1);
    wr(12'h000, 32'h7f);
    rd(12'h000, 32'h3f);
    chk(ldo_hrdata, 32'h7f);
    chk({30'h0, temp_sense_enable, temp_sense_range}, 32'h3);
    wr(12'h000, 32'h20);
    chk({31'h0, temp_sense_range}, 32'h0);
    wr(12'h010, 32'hff);
    wr(12'h000, 32'h00);
    chk({31'h0, temp_sense_enable}, 32'h0);
    wr(12'h008, 32'h1);
    @(posedge hclk);
    ref_stable_async <= 1'b1;
    wr(12'h000, 32'h80);
    chk({31'h0, reference_enable}, 32'h1);
    repeat (1200) @(posedge hclk);
    rd(12'h000, 32'h80);
    wait_ready();
    chk({31'h0, irq}, 32'h1);
    rd(12'h000, 32'hc0);
    rd(12'h004, 32'h1);
    chk({31'h0, irq}, 32'h0);
    @(posedge hclk);
    ref_stable_async <= 1'b0;
    repeat (6) @(posedge hclk);
    rd(12'h000, 32'h80);
    chk({31'h0, irq}, 32'h0);
    rd(12'h004, 32'h2);
    @(posedge hclk);
    ref_stable_async <= 1'b1;
    wait_ready();
    wr(12'h000, 32'h00);
    rd(12'h000, 32'h00);
    chk({31'h0, reference_ready}, 32'h0);
    rd(12'h004, 32'h3);
    rd(12'h004, 32'h0);
    wr(12'h000, 32'hbf);
    rd(12'h000, 32'hbf);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk({26'h0, reference_enable, temp_sense_enable, temp_sense_range,
         cmp_dac_out_en, converter_out_en, irq}, 32'h0);
    chk({31'h0, ldo_ready}, 32'h1);
    rd(12'h000, 32'h00);
    chk(ldo_hrdata, 32'h40);
    stop_test();
  end
endmodule : fixed_reference_control_tb
